// [rtl/strap_cs_map.vh]
// Purpose: Offsets, field positions, reset values and timing counts for the strap and select block.
// Assumes: Byte-wide I/O registers; one core clock at 40 MHz.
// Notes: Definitions only.
`ifndef STRAP_CS_MAP_VH
`define STRAP_CS_MAP_VH

// ****************************************
// Register offsets (16-bit I/O space)
// ****************************************
`define CS_TYPE_ADDR 16'hEF03
`define CS_BASE_ADDR 16'hEF04
`define CS_BASE_LAST 16'hEF23
`define CS_MASK_ADDR 16'hEF24
`define CS_MASK_LAST 16'hEF43
`define CS_BOOTSEL_ADDR 16'hEF44
`define CS_EXTSEL_ADDR 16'hEF45
`define CS_EXTSEL_LAST 16'hEF4C
`define CS_WIDTH16_ADDR 16'hEF57
`define CS_STRAP_ADDR 16'hEF58

// ****************************************
// Fields and reset values
// ****************************************
`define STRAP_BOOT16_BIT 0
`define STRAP_EMU_BIT 1
`define CS_REG_RESET 8'h00
`define BOOT_SEG_TOP 16'hFFFF
`define MASK_WIDTH 26

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_PS 25000
`define PIN_DRIVE_DELAY_NS 50

`endif

// [rtl/pin_sync3.v]
// Purpose: Three-stage pin synchroniser that accepts a change once stages two and three agree.
// Assumes: Inputs are asynchronous to the clock.
// Notes: Stage one feeds stage two only.
`timescale 1ns/1ps

module pin_sync3 #(
	parameter W = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	input wire clk,
	input wire rst_n,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);

	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;
	integer i;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
			q <= INIT;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (i = 0; i < W; i = i + 1) begin
				if (s2_r[i] == s3_r[i]) begin
					q[i] <= s3_r[i];
				end
			end
		end
	end

endmodule // pin_sync3

// [rtl/logical_select_match.v]
// Purpose: Decode of one logical chip select against base, mask and access type.
// Assumes: Mask bits set to one are don't-care; only the low 26 bits are maskable.
// Notes: Purely combinational.
`timescale 1ns/1ps
`include "strap_cs_map.vh"

module logical_select_match (
	input wire [31:0] addr,
	input wire is_io,
	input wire [31:0] base,
	input wire [`MASK_WIDTH-1:0] mask,
	input wire type_mem,
	output wire hit
);

	wire [31:0] full_mask;
	wire type_ok;

	assign full_mask = {{(32-`MASK_WIDTH){1'b0}}, mask};
	assign type_ok = type_mem ? !is_io : is_io;
	assign hit = type_ok && (((addr ^ base) & ~full_mask) == 32'h0000_0000);

endmodule // logical_select_match

// [rtl/strap_cs_top.v]
// Contract
// - While power-good is low, the SBHE pin is released and read as input.
// - On power-good rising, the SBHE level is captured as boot-width strap.
// - Strap 0 makes boot range accesses 8-bit; strap 1 makes them 16-bit.
// - In 8-bit boot mode every boot byte uses the low data lanes.
// - In 16-bit boot mode even bytes go low, odd bytes high, ignoring feedback.
// - A short delay after power-good rises, SBHE is driven again.
// - SA0 is an input during reset; floating pin pulls up to normal mode.
// - SA0 strap 0 with test pin low enters emulator mode, all drivers off.
// - A short delay after power-good rises, SA0 is driven again.
// - Boot select asserts for every memory access in the top 64 Kbytes once the drive delay after power-good has ended.
// - Software may add logical select ranges to the boot select.
// - Nine active-low selects: one boot select and eight programmable ones.
// - Register at EF57h forces each logical select to 16-bit width.
// - Forced 16-bit selects put even bytes low and odd bytes high.
// - Each logical select matches address range and I/O or memory type.
// - Each pin is driven from one or several logical selects.
// - Feedback low gives 16-bit access; high splits into 8-bit low-lane cycles.
//
// Purpose: Reset-time straps and chip select sizing of the external bus unit.
// Assumes: One access request per cycle from the CPU side; pins are outside this clock.
// Notes: Register window is byte-wide I/O reached through the CPU access port.
`timescale 1ns/1ps
`include "strap_cs_map.vh"

module strap_cs_top (
	input wire core_clk,
	input wire rstn,
	input wire power_good_reset_n,
	input wire test_n,
	input wire width16_feedback_n,
	input wire sbhe_pin_i,
	output reg sbhe_pin_o,
	output reg sbhe_pin_oe,
	input wire sa0_pin_i,
	output reg sa0_pin_o,
	output reg sa0_pin_oe,
	input wire bus_sbhe_n,
	input wire bus_sa0,
	input wire acc_valid,
	input wire acc_io,
	input wire acc_write,
	input wire [31:0] acc_addr,
	input wire [7:0] acc_wdata,
	output reg [7:0] acc_rdata,
	output reg acc_rvalid,
	output reg [8:0] cs_n,
	output reg cs_oe,
	output reg cyc_width16,
	output reg cyc_high_lane,
	output reg boot_width16,
	output reg emulator_mode
);

	// ****************************************
	// Reset release and timing constants
	// ****************************************
	localparam [31:0] DRIVE_DELAY_CYC_RAW =
		(`PIN_DRIVE_DELAY_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
	localparam [3:0] DRIVE_DELAY_CYC =
		(DRIVE_DELAY_CYC_RAW == 0) ? 4'h1 : DRIVE_DELAY_CYC_RAW[3:0];

	localparam [1:0] ST_RESET = 2'b00;
	localparam [1:0] ST_DELAY = 2'b01;
	localparam [1:0] ST_RUN = 2'b10;

	reg rst_meta_r;
	reg rst_sync_r;
	wire rst_n;

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	assign rst_n = rst_sync_r;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// The power-good input resets low so that the straps are taken on its first accepted rise.
	wire [4:0] pins_q;
	wire pg_s;
	wire test_n_s;
	wire fb_n_s;
	wire sbhe_s;
	wire sa0_s;

	pin_sync3 #(
		.W(5),
		.INIT(5'b11110)
	) u_pin_sync (
		.clk(core_clk),
		.rst_n(rst_n),
		.d({sa0_pin_i, sbhe_pin_i, width16_feedback_n, test_n, power_good_reset_n}),
		.q(pins_q)
	);

	assign pg_s = pins_q[0];
	assign test_n_s = pins_q[1];
	assign fb_n_s = pins_q[2];
	assign sbhe_s = pins_q[3];
	assign sa0_s = pins_q[4];

	// ****************************************
	// Strap capture and pin release sequence
	// ****************************************
	reg pg_prev_r;
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [3:0] delay_r;
	reg [3:0] delay_nxt;
	wire pg_rise;

	assign pg_rise = pg_s && !pg_prev_r;

	always @* begin
		state_nxt = state_r;
		delay_nxt = delay_r;
		case (state_r)
			ST_RESET: begin
				if (pg_rise) begin
					state_nxt = ST_DELAY;
					delay_nxt = DRIVE_DELAY_CYC;
				end
			end
			ST_DELAY: begin
				if (!pg_s) begin
					state_nxt = ST_RESET;
				end else if (delay_r == 4'h1) begin
					state_nxt = ST_RUN;
				end else begin
					delay_nxt = delay_r - 4'h1;
				end
			end
			ST_RUN: begin
				if (!pg_s) begin
					state_nxt = ST_RESET;
				end
			end
			default: begin
				state_nxt = ST_RESET;
			end
		endcase
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pg_prev_r <= 1'b0;
			state_r <= ST_RESET;
			delay_r <= 4'h0;
			boot_width16 <= 1'b0;
			emulator_mode <= 1'b0;
		end else begin
			pg_prev_r <= pg_s;
			state_r <= state_nxt;
			delay_r <= delay_nxt;
			if (pg_rise) begin
				boot_width16 <= sbhe_s;
				emulator_mode <= !sa0_s && !test_n_s;
			end
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	reg [7:0] type_r;
	reg [31:0] base_r [0:7];
	reg [`MASK_WIDTH-1:0] mask_r [0:7];
	reg [7:0] bootsel_r;
	reg [7:0] extsel_r [0:7];
	reg [7:0] width16_r;
	integer k;

	// Returns true when the I/O offset lies in the inclusive range.
	function in_range;
		input [15:0] off;
		input [15:0] lo;
		input [15:0] hi;
		begin
			in_range = (off >= lo) && (off <= hi);
		end
	endfunction

	// Index of a byte inside a group that starts at the given offset.
	function [4:0] group_pos;
		input [15:0] off;
		input [15:0] lo;
		reg [15:0] d;
		begin
			d = off - lo;
			group_pos = d[4:0];
		end
	endfunction

	wire reg_hit;
	wire [15:0] io_off;
	wire [4:0] base_pos;
	wire [4:0] mask_pos;
	wire [4:0] ext_pos;

	assign io_off = acc_addr[15:0];
	assign reg_hit = acc_valid && acc_io && (acc_addr[31:16] == 16'h0000);
	assign base_pos = group_pos(io_off, `CS_BASE_ADDR);
	assign mask_pos = group_pos(io_off, `CS_MASK_ADDR);
	assign ext_pos = group_pos(io_off, `CS_EXTSEL_ADDR);

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			type_r <= `CS_REG_RESET;
			bootsel_r <= `CS_REG_RESET;
			width16_r <= `CS_REG_RESET;
			for (k = 0; k < 8; k = k + 1) begin
				base_r[k] <= 32'h0000_0000;
				mask_r[k] <= {`MASK_WIDTH{1'b0}};
				extsel_r[k] <= `CS_REG_RESET;
			end
		end else if (reg_hit && acc_write) begin
			if (io_off == `CS_TYPE_ADDR) begin
				type_r <= acc_wdata;
			end
			if (io_off == `CS_BOOTSEL_ADDR) begin
				bootsel_r <= acc_wdata;
			end
			if (io_off == `CS_WIDTH16_ADDR) begin
				width16_r <= acc_wdata;
			end
			if (in_range(io_off, `CS_BASE_ADDR, `CS_BASE_LAST)) begin
				base_r[base_pos[4:2]][base_pos[1:0]*8 +: 8] <= acc_wdata;
			end
			if (in_range(io_off, `CS_MASK_ADDR, `CS_MASK_LAST)) begin
				if (mask_pos[1:0] == 2'b11) begin
					mask_r[mask_pos[4:2]][25:24] <= acc_wdata[1:0];
				end else begin
					mask_r[mask_pos[4:2]][mask_pos[1:0]*8 +: 8] <= acc_wdata;
				end
			end
			if (in_range(io_off, `CS_EXTSEL_ADDR, `CS_EXTSEL_LAST)) begin
				extsel_r[ext_pos[2:0]] <= acc_wdata;
			end
		end
	end

	// Readback; unmapped offsets answer zero.
	reg [7:0] rdata_nxt;
	reg [31:0] mask_word;

	always @* begin
		rdata_nxt = 8'h00;
		mask_word = {{(32-`MASK_WIDTH){1'b0}}, mask_r[mask_pos[4:2]]};
		if (io_off == `CS_TYPE_ADDR) begin
			rdata_nxt = type_r;
		end else if (io_off == `CS_BOOTSEL_ADDR) begin
			rdata_nxt = bootsel_r;
		end else if (io_off == `CS_WIDTH16_ADDR) begin
			rdata_nxt = width16_r;
		end else if (io_off == `CS_STRAP_ADDR) begin
			rdata_nxt[`STRAP_BOOT16_BIT] = boot_width16;
			rdata_nxt[`STRAP_EMU_BIT] = emulator_mode;
		end else if (in_range(io_off, `CS_BASE_ADDR, `CS_BASE_LAST)) begin
			rdata_nxt = base_r[base_pos[4:2]][base_pos[1:0]*8 +: 8];
		end else if (in_range(io_off, `CS_MASK_ADDR, `CS_MASK_LAST)) begin
			rdata_nxt = mask_word[mask_pos[1:0]*8 +: 8];
		end else if (in_range(io_off, `CS_EXTSEL_ADDR, `CS_EXTSEL_LAST)) begin
			rdata_nxt = extsel_r[ext_pos[2:0]];
		end
	end

	// ****************************************
	// Logical select decode
	// ****************************************
	wire [7:0] lcs_hit;

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_lcs
			logical_select_match u_match (
				.addr(acc_addr),
				.is_io(acc_io),
				.base(base_r[g]),
				.mask(mask_r[g]),
				.type_mem(type_r[g]),
				.hit(lcs_hit[g])
			);
		end
	endgenerate

	wire boot_hit;
	wire boot_pin;
	wire forced16;
	wire [7:0] pin_hit;

	assign boot_hit = !acc_io && (acc_addr[31:16] == `BOOT_SEG_TOP);
	assign boot_pin = boot_hit || (|(lcs_hit & bootsel_r));
	assign forced16 = |(lcs_hit & width16_r);

	generate
		for (g = 0; g < 8; g = g + 1) begin : g_pin
			assign pin_hit[g] = |(lcs_hit & extsel_r[g]);
		end
	endgenerate

	// ****************************************
	// Access width and lane steering
	// ****************************************
	// Boot range width comes from the strap alone, so a boot ROM needs no feedback logic.
	reg width16_nxt;

	always @* begin
		if (boot_hit) begin
			width16_nxt = boot_width16;
		end else if (forced16) begin
			width16_nxt = 1'b1;
		end else begin
			width16_nxt = !fb_n_s;
		end
	end

	// ****************************************
	// Output registers
	// ****************************************
	wire drivers_on;

	assign drivers_on = (state_r == ST_RUN) && !emulator_mode;

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_rdata <= 8'h00;
			acc_rvalid <= 1'b0;
			cs_n <= 9'h1FF;
			cs_oe <= 1'b0;
			cyc_width16 <= 1'b0;
			cyc_high_lane <= 1'b0;
			sbhe_pin_o <= 1'b1;
			sbhe_pin_oe <= 1'b0;
			sa0_pin_o <= 1'b0;
			sa0_pin_oe <= 1'b0;
		end else begin
			acc_rvalid <= reg_hit && !acc_write;
			acc_rdata <= (reg_hit && !acc_write) ? rdata_nxt : 8'h00;
			if (acc_valid && (state_r == ST_RUN)) begin
				cs_n <= ~{pin_hit, boot_pin};
				cyc_width16 <= width16_nxt;
				cyc_high_lane <= width16_nxt && acc_addr[0];
			end else begin
				cs_n <= 9'h1FF;
				cyc_width16 <= 1'b0;
				cyc_high_lane <= 1'b0;
			end
			cs_oe <= drivers_on;
			sbhe_pin_o <= bus_sbhe_n;
			sbhe_pin_oe <= drivers_on;
			sa0_pin_o <= bus_sa0;
			sa0_pin_oe <= drivers_on;
		end
	end

endmodule // strap_cs_top

// [bench/strap_cs_top_props.sv]
// Purpose: Port timing relations of the strap and select block.
// Assumes: One clock domain; rstn low holds everything idle.
// Notes: Bound to strap_cs_top after the module.
`timescale 1ns/1ps

module strap_cs_props (
	input wire core_clk,
	input wire rstn,
	input wire power_good_reset_n,
	input wire sbhe_pin_i,
	input wire sbhe_pin_oe,
	input wire sa0_pin_oe,
	input wire acc_valid,
	input wire acc_io,
	input wire acc_write,
	input wire [31:0] acc_addr,
	input wire [7:0] acc_rdata,
	input wire acc_rvalid,
	input wire [8:0] cs_n,
	input wire cs_oe,
	input wire cyc_width16,
	input wire cyc_high_lane,
	input wire boot_width16,
	input wire emulator_mode
);
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	// The enables stay up one cycle after a power-good fall stops the selects, so gate on the pin.
	wire boot_acc = acc_valid && !acc_io && acc_addr[31:16] == 16'hFFFF && cs_oe
		&& power_good_reset_n;

	// ****************************************
	// Relations
	// ****************************************
	AST_RELEASE: assert property (!power_good_reset_n [*8] |-> !sbhe_pin_oe && !sa0_pin_oe)
		else $error("strap pins driven while power-good low");
	AST_STRAP_SBHE: assert property ($rose(sbhe_pin_oe) |-> boot_width16 == $past(sbhe_pin_i))
		else $error("boot width strap differs from released pin level");
	AST_DRIVE_LATE: assert property ($rose(sbhe_pin_oe) || $rose(sa0_pin_oe)
		|-> $past(power_good_reset_n, 5) && !emulator_mode)
		else $error("pin driven too early or in emulator mode");
	AST_DRIVE_BACK: assert property (power_good_reset_n [*8] ##1 power_good_reset_n [*8]
		##1 !emulator_mode |-> sbhe_pin_oe && sa0_pin_oe)
		else $error("pins not driven again after power-good");
	AST_EMU_OFF: assert property (emulator_mode |-> !cs_oe && !sbhe_pin_oe && !sa0_pin_oe)
		else $error("driver enabled in emulator mode");
	AST_BOOT_CS: assert property (boot_acc |=> !cs_n[0])
		else $error("boot select missing for top segment");
	AST_BOOT_WIDTH: assert property (boot_acc |=> cyc_width16 == boot_width16
		&& cyc_high_lane == (boot_width16 && $past(acc_addr[0])))
		else $error("boot access width or lane wrong");
	AST_IDLE_CS: assert property (!acc_valid |=> cs_n == 9'h1FF && !cyc_width16 && !cyc_high_lane)
		else $error("select or width active without access");
	AST_REG_READ: assert property (acc_valid && acc_io && !acc_write
		&& acc_addr[31:16] == 16'h0000 |=> acc_rvalid)
		else $error("register read not answered");
	AST_RDATA_IDLE: assert property (!acc_rvalid |-> acc_rdata == 8'h00)
		else $error("read data not zero outside answer");
endmodule // strap_cs_props

bind strap_cs_top strap_cs_props u_strap_cs_props (.core_clk, .rstn, .power_good_reset_n,
	.sbhe_pin_i, .sbhe_pin_oe, .sa0_pin_oe, .acc_valid, .acc_io, .acc_write, .acc_addr,
	.acc_rdata, .acc_rvalid, .cs_n, .cs_oe, .cyc_width16, .cyc_high_lane, .boot_width16,
	.emulator_mode);

// [bench/pin_side_model.sv]
// Purpose: Board straps, emulator pod and 16-bit memory seen at the strap pins.
// Assumes: Released pins settle to their resistor level at once.
// Notes: Behavioural only.
`timescale 1ns/1ps

module pin_side_model (
	input wire sbhe_pin_o,
	input wire sbhe_pin_oe,
	input wire sa0_pin_o,
	input wire sa0_pin_oe,
	input wire strap_boot16,
	input wire pod_attached,
	input wire test_lift,
	output wire sbhe_pin_i,
	output wire sa0_pin_i,
	output wire test_n,
	output wire [1:0] mem_lanes
);
	// ****************************************
	// Wire levels
	// ****************************************
	assign sbhe_pin_i = sbhe_pin_oe ? sbhe_pin_o : strap_boot16;
	// Only the pod pulls the address pin low; otherwise the weak pull-up wins.
	assign sa0_pin_i = sa0_pin_oe ? sa0_pin_o : !pod_attached;
	// The lift keeps the test pin high with the pod on, so an address strap alone is exercised.
	assign test_n = !pod_attached || test_lift;
	assign mem_lanes = {!sbhe_pin_i, !sa0_pin_i};
endmodule // pin_side_model

// [bench/tb_strap_cs_top.sv]
// Purpose: Self-checking bench for straps, boot select and logical selects.
// Assumes: Inputs change on the falling edge; seed fixed.
// Notes: Pin side comes from pin_side_model.
`timescale 1ns/1ps

module tb_strap_cs_top;
	reg core_clk = 1'b0;
	reg rstn = 1'b0;
	reg power_good_reset_n = 1'b0;
	reg width16_feedback_n = 1'b1;
	reg bus_sbhe_n = 1'b1;
	reg bus_sa0 = 1'b0;
	reg acc_valid = 1'b0;
	reg acc_io = 1'b0;
	reg acc_write = 1'b0;
	reg [31:0] acc_addr = 32'h0;
	reg [7:0] acc_wdata = 8'h00;
	reg strap_boot16 = 1'b1;
	reg pod_attached = 1'b0;
	reg test_lift = 1'b0;
	wire test_n, sbhe_pin_i, sbhe_pin_o, sbhe_pin_oe, sa0_pin_i, sa0_pin_o, sa0_pin_oe;
	wire acc_rvalid, cs_oe, cyc_width16, cyc_high_lane, boot_width16, emulator_mode;
	wire [7:0] acc_rdata;
	wire [8:0] cs_n;
	wire [1:0] mem_lanes;
	integer err_total = 0;
	integer compares = 0;
	integer k;
	reg [31:0] r;
	reg [7:0] ext_sel [1:8];
	reg [7:0] boot_add;
	reg [7:0] w16;
	reg w;

	always #12.5 core_clk = ~core_clk;

	strap_cs_top u_strap_cs_top (.core_clk, .rstn, .power_good_reset_n, .test_n,
		.width16_feedback_n, .sbhe_pin_i, .sbhe_pin_o, .sbhe_pin_oe, .sa0_pin_i, .sa0_pin_o,
		.sa0_pin_oe, .bus_sbhe_n, .bus_sa0, .acc_valid, .acc_io, .acc_write, .acc_addr,
		.acc_wdata, .acc_rdata, .acc_rvalid, .cs_n, .cs_oe, .cyc_width16, .cyc_high_lane,
		.boot_width16, .emulator_mode);
	pin_side_model u_pin_side_model (.sbhe_pin_o, .sbhe_pin_oe, .sa0_pin_o, .sa0_pin_oe,
		.strap_boot16, .pod_attached, .test_lift, .sbhe_pin_i, .sa0_pin_i, .test_n, .mem_lanes);

	// ****************************************
	// Tasks
	// ****************************************
	task chk(input [8*8-1:0] name, input [31:0] seen, input [31:0] exp);
	begin
		compares = compares + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("MISMATCH %0s exp %0h seen %0h", name, exp, seen);
		end
	end
	endtask

	task acc(input io, input wr, input [31:0] a, input [7:0] d);
	begin
		@(negedge core_clk);
		acc_valid = 1'b1;
		acc_io = io;
		acc_write = wr;
		acc_addr = a;
		acc_wdata = d;
		@(negedge core_clk);
		acc_valid = 1'b0;
	end
	endtask

	task rd(input [15:0] a, input [7:0] e);
	begin
		acc(1'b1, 1'b0, {16'h0000, a}, 8'h00);
		chk("rdata", acc_rdata, e);
	end
	endtask

	task power(input b16, input pod, input lift);
	begin
		@(negedge core_clk);
		power_good_reset_n = 1'b0;
		strap_boot16 = b16;
		pod_attached = pod;
		test_lift = lift;
		repeat (12) @(negedge core_clk);
		chk("oe_low", {sbhe_pin_oe, sa0_pin_oe, cs_oe}, 0);
		chk("sa0_in", sa0_pin_i, !pod);
		acc(1'b0, 1'b0, 32'hFFFF0000, 8'h00);
		chk("cs_early", cs_n, 9'h1FF);
		power_good_reset_n = 1'b1;
		repeat (20) @(negedge core_clk);
		chk("straps", {boot_width16, emulator_mode}, {b16, pod & !lift});
		chk("drive", {sbhe_pin_oe, sa0_pin_oe, cs_oe}, (pod & !lift) ? 0 : 7);
		acc(1'b0, 1'b0, 32'hFFFFFFFF, 8'h00);
		chk("boot_top", {cs_n[0], cyc_width16, cyc_high_lane}, {1'b0, b16, b16});
		repeat (3) begin
			r = $urandom;
			acc(1'b0, 1'b0, {16'hFFFF, r[15:0]}, 8'h00);
			chk("boot_cs", cs_n[0], 0);
			chk("boot_w", {cyc_width16, cyc_high_lane}, {b16, b16 & r[0]});
		end
	end
	endtask

	function [8:0] exp_cs(input integer n);
		integer j;
	begin
		exp_cs = 9'h1FF;
		for (j = 1; j < 9; j = j + 1)
			if (ext_sel[j][n]) exp_cs[j] = 1'b0;
		if (boot_add[n]) exp_cs[0] = 1'b0;
	end
	endfunction

	task tally_and_finish;
	begin
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		r = $urandom(97);
		repeat (16) @(negedge core_clk);
		rstn = 1'b1;
		repeat (4) @(negedge core_clk);
		rd(16'hEF57, 8'h00);
		power(1'b1, 1'b0, 1'b0);
		acc(1'b1, 1'b1, 32'h0000EF58, 8'hFF);
		rd(16'hEF58, 8'h01);
		rd(16'hEF60, 8'h00);
		r = $urandom;
		w16 = r[7:0];
		boot_add = 8'h04;
		acc(1'b1, 1'b1, 32'h0000EF03, 8'hFF);
		acc(1'b1, 1'b1, 32'h0000EF57, w16);
		acc(1'b1, 1'b1, 32'h0000EF44, boot_add);
		rd(16'hEF57, w16);
		for (k = 0; k < 8; k = k + 1) begin
			ext_sel[k + 1] = (k == 0) ? 8'h03 : (8'h01 << k);
			acc(1'b1, 1'b1, 32'h0000EF06 + 4 * k, 8'h10 + k[7:0]);
			acc(1'b1, 1'b1, 32'h0000EF24 + 4 * k, 8'hFF);
			acc(1'b1, 1'b1, 32'h0000EF45 + k, ext_sel[k + 1]);
		end
		for (k = 0; k < 8; k = k + 1) begin
			r = $urandom;
			width16_feedback_n = r[8];
			w = w16[k] | !r[8];
			repeat (5) @(negedge core_clk);
			acc(1'b0, 1'b0, {8'h00, 8'h10 + k[7:0], 8'h00, r[7:0]}, 8'h00);
			chk("pin_cs", cs_n, exp_cs(k));
			chk("lcs_w", {cyc_width16, cyc_high_lane}, {w, w & r[0]});
			acc(1'b1, 1'b0, {8'h00, 8'h10 + k[7:0], 8'h00, r[7:0]}, 8'h00);
			chk("io_type", cs_n, 9'h1FF);
		end
		for (k = 0; k < 3; k = k + 1) begin
			{bus_sbhe_n, bus_sa0} = k[1:0];
			repeat (2) @(negedge core_clk);
			chk("lanes", mem_lanes, 3 - k);
		end
		power(1'b0, 1'b1, 1'b1);
		power(1'b0, 1'b1, 1'b0);
		power(1'b0, 1'b0, 1'b0);
		tally_and_finish;
	end

	initial begin
		#(25 * 20000);
		err_total = err_total + 1;
		tally_and_finish;
	end
endmodule // tb_strap_cs_top
